// ==== tcr_phase_gen.sv ====
// Machine cycle phase generator: state, sample and update strobes.
// Assumes i_clk is the oscillator clock.
`timescale 1ns/1ps
module tcr_phase_gen #(
    parameter int unsigned P_OSC_PER_MC = tcr_pkg::OSC_PER_MC
) (
    input  wire logic   i_clk,
    input  wire logic   i_reset,
    tcr_phase_if.src    ph
);
    if (P_OSC_PER_MC > 16 || P_OSC_PER_MC <= tcr_pkg::SAMPLE_IDX ||
        (P_OSC_PER_MC % 2) != 0) begin : g_chk
        $error("tcr_phase_gen: unsupported machine cycle length");
    end

    logic [3:0] osc_cnt_r;
    wire  [3:0] osc_cnt_nxt;

    assign osc_cnt_nxt = (osc_cnt_r == 4'(P_OSC_PER_MC - 1)) ? 4'h0
                                                            : osc_cnt_r + 4'h1;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            osc_cnt_r     <= 4'h0;
            ph.state_stb  <= 1'b0;
            ph.sample_stb <= 1'b0;
            ph.update_stb <= 1'b0;
        end else begin
            osc_cnt_r     <= osc_cnt_nxt;
            ph.state_stb  <= osc_cnt_nxt[0];
            ph.sample_stb <= osc_cnt_nxt == 4'(tcr_pkg::SAMPLE_IDX);
            ph.update_stb <= osc_cnt_nxt == 4'(tcr_pkg::UPDATE_IDX);
        end
    end
endmodule // tcr_phase_gen

// ==== tcr_phase_if.sv ====
// Machine cycle phase strobes passed from the phase generator.
// Assumes all users sit on the oscillator clock.
`timescale 1ns/1ps
interface tcr_phase_if;
    logic state_stb;
    logic sample_stb;
    logic update_stb;

    modport src (output state_stb, output sample_stb, output update_stb);
    modport dst (input  state_stb, input  sample_stb, input  update_stb);
endinterface

// ==== tcr_pin_model.sv ====
// Model of the external count and trigger pins of the timer block.
// Assumes the bench calls fall() from its main sequence only.
`timescale 1ns/1ps
module tcr_pin_model (
    input  wire logic i_clk,
    output logic      o_count_pin,
    output logic      o_trigger_pin
);
    // ******************************************************
    // Pin drive
    // ******************************************************
    // Over one machine cycle, plus margin for the input synchroniser
    localparam int unsigned HOLD = 14;

    // Port pins have pull-ups, so idle is high
    initial begin
        o_count_pin   = 1'b1;
        o_trigger_pin = 1'b1;
    end

    // One falling edge; each level stands HOLD clocks
    task automatic fall(input bit trig);
        repeat (HOLD) @(posedge i_clk);
        if (trig) begin
            o_trigger_pin <= 1'b0;
        end else begin
            o_count_pin <= 1'b0;
        end
        repeat (HOLD) @(posedge i_clk);
        o_trigger_pin <= 1'b1;
        o_count_pin   <= 1'b1;
        repeat (HOLD) @(posedge i_clk);
    endtask
endmodule // tcr_pin_model

// ==== tcr_pin_sampler.sv ====
// Pin synchroniser and once-per-machine-cycle sampler with fall detect.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps
module tcr_pin_sampler (
    input  wire logic   i_clk,
    input  wire logic   i_reset,
    tcr_phase_if.dst    ph,
    input  wire logic   i_pin,
    output logic        o_level,
    output logic        o_fall
);
    logic sync1_r;
    logic sync2_r;

    // Fall = high at the last sample point, low at this one
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1_r <= tcr_pkg::PIN_IDLE;
            sync2_r <= tcr_pkg::PIN_IDLE;
            o_level <= tcr_pkg::PIN_IDLE;
            o_fall  <= 1'b0;
        end else begin
            sync1_r <= i_pin;
            sync2_r <= sync1_r;
            o_fall  <= ph.sample_stb & o_level & ~sync2_r;
            if (ph.sample_stb) begin
                o_level <= sync2_r;
            end
        end
    end
endmodule // tcr_pin_sampler

// ==== tcr_pkg.sv ====
// Constants shared by the timer 2 capture/reload counter files.
// Assumes the oscillator clock drives every flip-flop of the block.
package tcr_pkg;

    // ******************************************************
    // Register addresses in the special function space
    // ******************************************************
    localparam logic [7:0] ADDR_CTRL = 8'hC8;
    localparam logic [7:0] ADDR_MODE = 8'hC9;
    localparam logic [7:0] ADDR_CAPL = 8'hCA;
    localparam logic [7:0] ADDR_CAPH = 8'hCB;
    localparam logic [7:0] ADDR_CNTL = 8'hCC;
    localparam logic [7:0] ADDR_CNTH = 8'hCD;

    // ******************************************************
    // Field positions
    // ******************************************************
    localparam int unsigned BIT_OVF   = 7;
    localparam int unsigned BIT_EXT   = 6;
    localparam int unsigned BIT_RXSEL = 5;
    localparam int unsigned BIT_TXSEL = 4;
    localparam int unsigned BIT_TRGEN = 3;
    localparam int unsigned BIT_RUN   = 2;
    localparam int unsigned BIT_CSRC  = 1;
    localparam int unsigned BIT_CPRL  = 0;
    localparam int unsigned BIT_DOWN_COUNT_ENABLE  = 0;
    localparam int unsigned BIT_OE    = 1;

    // ******************************************************
    // Reset values and count limit
    // ******************************************************
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [1:0]  MODE_RST = 2'h0;
    localparam logic [15:0] CAP_RST  = 16'h0000;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic        PIN_IDLE = 1'b1;
    localparam logic [7:0]  RD_NONE  = 8'h00;

    // ******************************************************
    // Timing: oscillator period in ns, cycle length in states, the rest in oscillator periods
    // ******************************************************
    localparam int unsigned OSC_PERIOD_NS = 25;
    localparam int unsigned OSC_PER_STATE = 2;
    localparam int unsigned STATES_PER_MC = 6;
    localparam int unsigned OSC_PER_MC    = OSC_PER_STATE * STATES_PER_MC;
    // Phase index = (state - 1) * 2 + (phase - 1)
    localparam int unsigned SAMPLE_IDX    = 4 * OSC_PER_STATE + 1;
    localparam int unsigned UPDATE_IDX    = 2 * OSC_PER_STATE;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_RELOAD,
        MODE_CAPTURE,
        MODE_BAUD
    } tcr_mode_t;

endpackage

// ==== tcr_timer2.sv ====
// Timer 2: 16-bit timer/counter with capture, auto-reload and baud mode.
// Assumes i_clk is the oscillator and the CPU drives the register port
// synchronously; count and trigger pins are asynchronous.
//
// Overview of operation
// [R1] Software keeps unused addresses clear; unmapped reads here return 0.
// [R2] Count overflow sets control bit 7; only software clears it.
// [R3] Overflow flag is never set while either baud source bit is 1.
// [R4] Enabled trigger pin fall causing capture or reload sets bit 6.
// [R5] Set trigger flag raises the timer interrupt request.
// [R6] With down count enabled the trigger flag raises no interrupt.
// [R7] Bit 5 routes this timer's overflows to receiver clock, else other.
// [R8] Bit 4 routes this timer's overflows to transmit clock, else other.
// [R9] Bit 3 lets trigger falls capture or reload unless in baud mode; here not in up/down mode either.
// [R10] Bit 2 starts counting when 1, timer fully off when 0; here enabled trigger falls still capture or reload at 0.
// [R11] Bit 1 picks machine cycles at 0, count pin falls at 1.
// [R12] Bit 0 picks capture at 1, reload on overflow or trigger at 0.
// [R13] Any baud source bit forces reload on every overflow.
// [R14] Three modes, capture, reload and baud, plus off via run.
// [R15] Timer operation counts once per 12 oscillator periods.
// [R16] Count pin sampled once per cycle; high then low gives one count.
// [R17] That count becomes visible at update phase of the next cycle.
// [R18] Count pin levels must last at least one full machine cycle.
// [R19] Capture mode without trigger is a plain 16-bit overflowing timer.
// [R20] Capture trigger copies the count into capture bytes, sets bit 6.
// [R21] Reload mode overflow past FFFF sets bit 7 and loads capture value.
// [R22] Baud mode timer counts every state time, half the oscillator.
// [R23] Down count enable resets to 0, so counting is upward.
// [R24] Low and high count bytes form one 16-bit counter.
// [R25] Interrupt request is overflow flag OR trigger flag.
`timescale 1ns/1ps
module tcr_timer2 (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic [7:0] i_sfr_wdata,
    input  wire logic       i_sfr_rd,
    output logic      [7:0] o_sfr_rdata,
    output logic            o_sfr_hit,
    input  wire logic       i_count_pin,
    input  wire logic       i_trigger_pin,
    input  wire logic       i_other_rx_tick,
    input  wire logic       i_other_tx_tick,
    output logic            o_rx_tick,
    output logic            o_tx_tick,
    output logic            o_irq
);

    // ******************************************************
    // Phase timing and pin sampling
    // ******************************************************
    tcr_phase_if u_ph ();

    tcr_phase_gen u_phase_gen (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .ph      (u_ph)
    );

    logic cnt_level;
    logic cnt_fall;
    logic trg_level;
    logic trg_fall;

    tcr_pin_sampler u_count_smp (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .ph      (u_ph),
        .i_pin   (i_count_pin),
        .o_level (cnt_level),
        .o_fall  (cnt_fall)
    );

    tcr_pin_sampler u_trig_smp (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .ph      (u_ph),
        .i_pin   (i_trigger_pin),
        .o_level (trg_level),
        .o_fall  (trg_fall)
    );

    // ******************************************************
    // Registers
    // ******************************************************
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [1:0]  mode_r;
    logic [1:0]  mode_nxt;
    logic [15:0] cap_r;
    logic [15:0] cap_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] cnt_calc;
    logic        pend_r;

    // ******************************************************
    // Register port decode
    // ******************************************************
    wire wr_ctrl = i_sfr_wr & (i_sfr_addr == tcr_pkg::ADDR_CTRL);
    wire wr_mode = i_sfr_wr & (i_sfr_addr == tcr_pkg::ADDR_MODE);
    wire wr_capl = i_sfr_wr & (i_sfr_addr == tcr_pkg::ADDR_CAPL);
    wire wr_caph = i_sfr_wr & (i_sfr_addr == tcr_pkg::ADDR_CAPH);
    wire wr_cntl = i_sfr_wr & (i_sfr_addr == tcr_pkg::ADDR_CNTL);
    wire wr_cnth = i_sfr_wr & (i_sfr_addr == tcr_pkg::ADDR_CNTH);

    wire addr_hit = (i_sfr_addr >= tcr_pkg::ADDR_CTRL) &&
                    (i_sfr_addr <= tcr_pkg::ADDR_CNTH);

    // Unmapped addresses read as zero and claim nothing
    wire [7:0] rd_mux =
        (i_sfr_addr == tcr_pkg::ADDR_CTRL) ? ctrl_r :
        (i_sfr_addr == tcr_pkg::ADDR_MODE) ? {6'h00, mode_r} :
        (i_sfr_addr == tcr_pkg::ADDR_CAPL) ? cap_r[7:0] :
        (i_sfr_addr == tcr_pkg::ADDR_CAPH) ? cap_r[15:8] :
        (i_sfr_addr == tcr_pkg::ADDR_CNTL) ? cnt_r[7:0] :
        (i_sfr_addr == tcr_pkg::ADDR_CNTH) ? cnt_r[15:8] :
                                             tcr_pkg::RD_NONE; // R1

    // ******************************************************
    // Mode decode
    // ******************************************************
    wire ovf_flag  = ctrl_r[tcr_pkg::BIT_OVF];
    wire ext_flag  = ctrl_r[tcr_pkg::BIT_EXT];
    wire rx_sel    = ctrl_r[tcr_pkg::BIT_RXSEL];
    wire tx_sel    = ctrl_r[tcr_pkg::BIT_TXSEL];
    wire trig_en   = ctrl_r[tcr_pkg::BIT_TRGEN];
    wire run       = ctrl_r[tcr_pkg::BIT_RUN];
    wire src_pin   = ctrl_r[tcr_pkg::BIT_CSRC];
    wire cap_sel   = ctrl_r[tcr_pkg::BIT_CPRL];
    wire down_en   = mode_r[tcr_pkg::BIT_DOWN_COUNT_ENABLE];
    wire baud      = rx_sel | tx_sel;

    tcr_pkg::tcr_mode_t op_mode;
    assign op_mode = !run    ? tcr_pkg::MODE_OFF :
                     baud    ? tcr_pkg::MODE_BAUD :
                     cap_sel ? tcr_pkg::MODE_CAPTURE
                             : tcr_pkg::MODE_RELOAD; // R14

    wire updown    = down_en & ~cap_sel & ~baud;
    wire count_dn  = updown & ~trg_level;

    // Pin counts wait for the update phase of the following cycle
    wire pend_nxt  = cnt_fall | (pend_r & ~u_ph.update_stb); // R16
    wire pin_tick  = pend_r & u_ph.update_stb; // R17
    wire clk_tick  = baud ? u_ph.state_stb : u_ph.update_stb; // R15 R22
    wire inc_tick  = run & (src_pin ? pin_tick : clk_tick); // R10 R11

    wire at_max    = cnt_r == tcr_pkg::CNT_MAX;
    wire ovf_evt   = inc_tick & ~count_dn & at_max; // R24
    wire unf_evt   = inc_tick & count_dn & (cnt_r == cap_r);
    wire roll_evt  = ovf_evt | unf_evt;
    // An overflow implies run, so only capture mode keeps counting on
    wire rld_ovf   = ovf_evt & (op_mode != tcr_pkg::MODE_CAPTURE); // R13 R21

    // In up/down mode the trigger pin is direction, not an event
    wire trig_act  = trg_fall & trig_en & ~updown; // R9
    wire cap_evt   = trig_act & cap_sel & ~baud; // R20
    wire rld_trig  = trig_act & ~cap_sel & ~baud; // R12
    wire ovf_set   = roll_evt & ~baud; // R2 R3 R19
    wire ext_set   = trig_act; // R4
    wire ext_tog   = roll_evt & updown;
    wire irq_nxt   = ovf_flag | (ext_flag & ~down_en); // R5 R6 R25

    wire [15:0] cnt_step = count_dn ? cnt_r - 16'h0001 : cnt_r + 16'h0001;

    // ******************************************************
    // Next state
    // ******************************************************
    always_comb begin
        if (rld_ovf || rld_trig) begin
            cnt_calc = cap_r; // R21
        end else if (unf_evt) begin
            cnt_calc = tcr_pkg::CNT_MAX;
        end else if (inc_tick) begin
            cnt_calc = cnt_step; // R24
        end else begin
            cnt_calc = cnt_r;
        end
    end

    // Software writes to the count win over the hardware update
    assign cnt_nxt = {wr_cnth ? i_sfr_wdata : cnt_calc[15:8],
                      wr_cntl ? i_sfr_wdata : cnt_calc[7:0]};

    assign cap_nxt = cap_evt ? cnt_r :
                     {wr_caph ? i_sfr_wdata : cap_r[15:8],
                      wr_capl ? i_sfr_wdata : cap_r[7:0]};

    // Hardware setting of a flag beats a software clear in the same cycle
    always_comb begin
        ctrl_nxt = wr_ctrl ? i_sfr_wdata : ctrl_r;
        ctrl_nxt[tcr_pkg::BIT_OVF] = ctrl_nxt[tcr_pkg::BIT_OVF] | ovf_set;
        ctrl_nxt[tcr_pkg::BIT_EXT] =
            ext_set | (ctrl_nxt[tcr_pkg::BIT_EXT] ^ ext_tog); // R4
    end

    assign mode_nxt = wr_mode ? i_sfr_wdata[1:0] : mode_r;

    // ******************************************************
    // Flip-flops
    // ******************************************************
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_r <= tcr_pkg::CTRL_RST;
            mode_r <= tcr_pkg::MODE_RST; // R23
            cap_r  <= tcr_pkg::CAP_RST;
            cnt_r  <= tcr_pkg::CNT_RST;
            pend_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            cap_r  <= cap_nxt;
            cnt_r  <= cnt_nxt;
            pend_r <= pend_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_sfr_rdata <= tcr_pkg::RD_NONE;
            o_sfr_hit   <= 1'b0;
            o_irq       <= 1'b0;
            o_rx_tick   <= 1'b0;
            o_tx_tick   <= 1'b0;
        end else begin
            o_sfr_rdata <= i_sfr_rd ? rd_mux : tcr_pkg::RD_NONE;
            o_sfr_hit   <= (i_sfr_rd | i_sfr_wr) & addr_hit;
            o_irq       <= irq_nxt; // R25
            o_rx_tick   <= rx_sel ? ovf_evt : i_other_rx_tick; // R7
            o_tx_tick   <= tx_sel ? ovf_evt : i_other_tx_tick; // R8
        end
    end

    // ******************************************************
    // Assertions
    // ******************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    wire sw_cnt_wr = wr_cntl | wr_cnth;
    // Nothing but the machine cycle strobe may move the count
    wire timer_quiet = run & ~sw_cnt_wr & ~rld_trig & ~src_pin & ~baud;

    a_ovf_sets_flag: assert property ( // R2
        ovf_evt && !baud |=> ovf_flag)
        else $error("overflow did not set the overflow flag");

    a_baud_no_flag: assert property ( // R3
        $rose(ovf_flag) |-> $past(!baud) || $past(wr_ctrl))
        else $error("overflow flag set in baud mode");

    a_trig_captures: assert property ( // R20
        trg_fall && trig_en && cap_sel && !baud && !wr_capl && !wr_caph
        |=> cap_r == $past(cnt_r) && ext_flag)
        else $error("trigger fall did not capture the count");

    a_trig_ignored: assert property ( // R9
        trg_fall && !trig_en && !wr_capl && !wr_caph
        |=> cap_r == $past(cap_r))
        else $error("trigger fall acted with trigger disabled");

    a_irq_follows: assert property ( // R5
        ext_flag && !down_en ##1 ext_flag && !down_en |-> o_irq)
        else $error("trigger flag gave no interrupt");

    a_down_count_enable_no_irq: assert property ( // R6
        down_en && !ovf_flag ##1 down_en && !ovf_flag |-> !o_irq)
        else $error("interrupt raised in up/down mode by trigger flag");

    a_off_holds: assert property ( // R10
        !run && !sw_cnt_wr && !rld_trig |=> cnt_r == $past(cnt_r))
        else $error("count moved while stopped");

    a_timer_rate: assert property ( // R15
        run && !src_pin && !baud && !sw_cnt_wr && !rld_trig &&
        !count_dn && !at_max && u_ph.update_stb
        |=> cnt_r == $past(cnt_r) + 16'h0001 && timer_quiet
            ##1 timer_quiet [*7] |-> cnt_r == $past(cnt_r, 7))
        else $error("timer rate is not one per machine cycle");

    a_baud_rate: assert property ( // R22
        run && !src_pin && baud && !sw_cnt_wr && !at_max && u_ph.state_stb
        |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("baud mode did not count on the state strobe");

    a_pin_count_lag: assert property ( // R16 R17
        cnt_fall && run && src_pin && !baud && !updown && !sw_cnt_wr &&
        !rld_trig && !at_max
        |-> ##[1:7] (cnt_r != $past(cnt_r)))
        else $error("pin fall not counted by the next update phase");

    a_reload_value: assert property ( // R13 R21
        rld_ovf && !sw_cnt_wr |=> cnt_r == $past(cap_r))
        else $error("overflow did not reload the capture value");

    a_baud_routing: assert property ( // R7 R8
        rx_sel && tx_sel && ovf_evt |=> o_rx_tick && o_tx_tick)
        else $error("overflow not routed to the serial clocks");

    a_other_ticks: assert property ( // R7 R8
        !rx_sel && !tx_sel |=> o_rx_tick == $past(i_other_rx_tick) &&
            o_tx_tick == $past(i_other_tx_tick))
        else $error("other timer ticks not passed to the serial clocks");

    // Capture mode counts on through zero; the reload modes reload
    a_cap_wraps: assert property ( // R19
        ovf_evt && cap_sel && !baud && !sw_cnt_wr |=> cnt_r == 16'h0000)
        else $error("capture mode overflow did not wrap to zero");

    a_trig_reloads: assert property ( // R12
        rld_trig && !sw_cnt_wr |=> cnt_r == $past(cap_r))
        else $error("trigger fall did not reload the count");

    a_trig_flag: assert property ( // R4
        trig_act |=> ext_flag)
        else $error("trigger event did not set the trigger flag");

    a_ovf_irq: assert property ( // R25
        ovf_flag |=> o_irq)
        else $error("overflow flag gave no interrupt");

    a_byte_carry: assert property ( // R24
        inc_tick && !count_dn && cnt_r[7:0] == 8'hFF && !rld_ovf &&
        !rld_trig && !sw_cnt_wr
        |=> cnt_r[15:8] == $past(cnt_r[15:8]) + 8'h01)
        else $error("low byte rollover did not carry into the high byte");

    a_pin_src_holds: assert property ( // R11
        run && src_pin && !pin_tick && !sw_cnt_wr && !rld_trig
        |=> cnt_r == $past(cnt_r))
        else $error("count moved in counter mode without a pin fall");

    a_off_no_tick: assert property ( // R14
        op_mode == tcr_pkg::MODE_OFF |-> !inc_tick)
        else $error("count tick while the timer is off");

    c_capture: cover property (cap_evt);
    c_trig_reload: cover property (rld_trig);
    c_baud_ovf: cover property (baud && ovf_evt);
    c_underflow: cover property (unf_evt);
    c_ext_toggle: cover property (ext_tog);

endmodule // tcr_timer2

// ==== testbench.sv ====
// Self-checking bench for the timer 2 block: register port tasks and
// directed tests. Assumes the pin model drives both external pins.
`timescale 1ns/1ps
module testbench;
    // ******************************************************
    // Signals and instances
    // ******************************************************
    localparam logic [7:0] A_CTL = tcr_pkg::ADDR_CTRL;
    localparam logic [7:0] A_MOD = tcr_pkg::ADDR_MODE;
    localparam logic [7:0] A_CAP = tcr_pkg::ADDR_CAPL;
    localparam logic [7:0] A_CNT = tcr_pkg::ADDR_CNTL;
    logic       i_clk    = 1'b0;
    logic       i_reset  = 1'b1;
    logic [7:0] addr     = 8'h00;
    logic       wr_en    = 1'b0;
    logic [7:0] wdata    = 8'h00;
    logic       rd_en    = 1'b0;
    logic       other_rx = 1'b0;
    logic       other_tx = 1'b0;
    logic [7:0] rdata;
    logic       hit, count_pin, trig_pin, rx_tick, tx_tick, irq;
    int         miscompares = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         rx_n = 0;
    int         tx_n = 0;

    tcr_timer2 dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_sfr_addr(addr),
        .i_sfr_wr(wr_en), .i_sfr_wdata(wdata), .i_sfr_rd(rd_en),
        .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_count_pin(count_pin),
        .i_trigger_pin(trig_pin), .i_other_rx_tick(other_rx),
        .i_other_tx_tick(other_tx), .o_rx_tick(rx_tick),
        .o_tx_tick(tx_tick), .o_irq(irq)
    );
    tcr_pin_model pins (
        .i_clk(i_clk), .o_count_pin(count_pin), .o_trigger_pin(trig_pin)
    );

    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    // Tick counters and a hang guard well above the run length
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (rx_tick === 1'b1) rx_n <= rx_n + 1;
        if (tx_tick === 1'b1) tx_n <= tx_n + 1;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    // ******************************************************
    // Tasks
    // ******************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge i_clk);
        addr  <= ad;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge i_clk);
        wr_en <= 1'b0;
    endtask

    task automatic wr16(input logic [7:0] ad, input logic [15:0] v);
        wr(ad, v[7:0]);
        wr(ad + 8'h01, v[15:8]);
    endtask

    // Data is registered, so it is taken 1 ns after the answer edge
    task automatic rd(input logic [7:0] ad, output logic [7:0] d,
                      output logic h);
        @(posedge i_clk);
        addr  <= ad;
        rd_en <= 1'b1;
        @(posedge i_clk);
        rd_en <= 1'b0;
        #1 d = rdata;
        h = hit;
    endtask

    task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] d;
        logic       h;
        rd(ad, d, h);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // Two reads span clocks apart see the same phase of the cycle
    task automatic delta(input logic [7:0] ctl, input int span,
                         input logic [7:0] exp);
        logic [7:0] a;
        logic [7:0] b;
        logic       h;
        wr(A_CTL, 8'h00);
        wr16(A_CNT, 16'h0000);
        wr(A_CTL, ctl);
        rd(A_CNT, a, h);
        repeat (span - 2) @(posedge i_clk);
        rd(A_CNT, b, h);
        chk({8'h00, 8'(b - a)}, {8'h00, exp});
    endtask

    task automatic settle();
        repeat (2) @(posedge i_clk);
        #1;
    endtask

    task automatic results();
        $display("Counts: %0d compared, %0d mismatched", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ******************************************************
    // Test sequence
    // ******************************************************
    initial begin
        logic [7:0] d;
        logic       h;
        int         r0;
        int         t0;
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        // Whole map reads zero; the address past it is not claimed
        for (int i = 0; i < 7; i++) begin
            rd(A_CTL + 8'(i), d, h);
            chk({8'h00, d}, 16'h0000);
            chk({15'h0, h}, {15'h0, 1'(i < 6)});
        end
        $display("Test done: reset values");
        delta(8'h04, 36, 8'h03);
        delta(8'h35, 12, 8'h06);
        delta(8'h30, 36, 8'h00);
        delta(8'h06, 36, 8'h00);
        $display("Test done: count rates");
        wr(A_CTL, 8'h00);
        wr16(A_CAP, 16'hFFF0);
        wr16(A_CNT, 16'hFFFE);
        wr(A_CTL, 8'h04);
        repeat (36) @(posedge i_clk);
        rdchk(A_CTL, 8'h84);
        rdchk(A_CNT + 8'h01, 8'hFF);
        chk({15'h0, irq}, 16'h0001);
        wr(A_CTL, 8'h00);
        rdchk(A_CTL, 8'h00);
        chk({15'h0, irq}, 16'h0000);
        wr16(A_CNT, 16'hFFFF);
        wr(A_CTL, 8'h05);
        repeat (24) @(posedge i_clk);
        rdchk(A_CNT + 8'h01, 8'h00);
        rdchk(A_CTL, 8'h85);
        $display("Test done: overflow");
        wr(A_CTL, 8'h00);
        wr16(A_CAP, 16'hFF00);
        wr16(A_CNT, 16'hFFFE);
        r0 = rx_n;
        wr(A_CTL, 8'h35);
        repeat (20) @(posedge i_clk);
        wr(A_CTL, 8'h31);
        chk(16'(rx_n - r0), 16'h0001);
        chk(16'(tx_n - r0), 16'h0001);
        rdchk(A_CNT + 8'h01, 8'hFF);
        rdchk(A_CTL, 8'h31);
        wr(A_CTL, 8'h00);
        r0 = rx_n;
        t0 = tx_n;
        @(posedge i_clk);
        other_rx <= 1'b1;
        other_tx <= 1'b1;
        @(posedge i_clk);
        other_rx <= 1'b0;
        other_tx <= 1'b0;
        settle();
        chk(16'(rx_n - r0), 16'h0001);
        chk(16'(tx_n - t0), 16'h0001);
        $display("Test done: baud mode");
        wr16(A_CNT, 16'h0000);
        wr(A_CTL, 8'h06);
        repeat (3) pins.fall(1'b0);
        rdchk(A_CNT, 8'h03);
        $display("Test done: event count");
        wr(A_CTL, 8'h00);
        wr16(A_CNT, 16'h1234);
        wr(A_CTL, 8'h09);
        pins.fall(1'b1);
        rdchk(A_CAP, 8'h34);
        rdchk(A_CAP + 8'h01, 8'h12);
        rdchk(A_CTL, 8'h49);
        chk({15'h0, irq}, 16'h0001);
        wr(A_CTL, 8'h01);
        wr(A_CNT, 8'h55);
        pins.fall(1'b1);
        rdchk(A_CAP, 8'h34);
        rdchk(A_CTL, 8'h01);
        wr(A_CTL, 8'h08);
        pins.fall(1'b1);
        rdchk(A_CNT, 8'h34);
        rdchk(A_CNT + 8'h01, 8'h12);
        rdchk(A_CTL, 8'h48);
        wr(A_MOD, 8'h01);
        settle();
        chk({15'h0, irq}, 16'h0000);
        // Up/down mode counting up: overflow reloads and toggles bit 6
        wr16(A_CNT, 16'hFFFF);
        wr(A_CTL, 8'h04);
        repeat (12) @(posedge i_clk);
        rdchk(A_CTL, 8'hC4);
        rdchk(A_CNT + 8'h01, 8'h12);
        wr(A_CTL, 8'h48);
        wr(A_MOD, 8'h00);
        settle();
        chk({15'h0, irq}, 16'h0001);
        $display("Test done: trigger");
        results();
    end
endmodule // testbench
